// >>> hdl/ace_control_egress.sv
// Purpose: port isolation control and egress block vector registers with routing verdict
// Assumes: one clock, plain register port, read data one cycle after the read strobe
// Notes: the forwarding datapath itself stays outside; this block only decides
//
// Operation
// - bit 0 turns on source identity checking of received requests
// - bit 1 blocks requests that carry translated addresses
// - bit 2 redirects peer-to-peer requests upstream
// - bit 3 redirects peer-to-peer completions upstream
// - bit 4 turns on upstream forwarding of received traffic
// - bit 5 turns on egress control using the vector
// - bit 6 applies direct translated peer-to-peer control to translated requests
// - control bits reset to zero; read-only upstream, writable downstream while clk_en is high
// - vector affects routing only while egress control is enabled
// - vector bit index equals switch port number
// - peer-to-peer request to a port whose vector bit is one is blocked, or redirected unless bit 6 forwards a translated one
// - vector bit of the owning port reads zero, ignores writes
// - merged even port: bits N and N plus one read zero
// - capability reports a vector size of sixteen ports downstream
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "ace_consts.svh"

module ace_control_egress (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // port identity straps, same clock domain
    input wire logic upstream_port,
    input wire logic merged_mode,
    input wire logic [`ACE_PORT_W-1:0] port_num,
    // register port
    input wire logic [`ACE_ADDR_W-1:0] reg_addr,
    input wire logic [`ACE_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`ACE_DATA_W-1:0] reg_rdata,
    // request to be judged
    input wire ace_pkg::ace_req_t req_in,
    // routing verdict, one cycle after the request
    output ace_pkg::ace_verdict_t verdict,
    // enables and vector size seen by the datapath
    output logic src_val_en,
    output logic up_fwd_en,
    output logic [7:0] vec_size
);
    import ace_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [`ACE_DATA_W-1:0] ctrl_r;
    logic [`ACE_DATA_W-1:0] ctrl_nxt;
    logic [`ACE_NUM_PORTS-1:0] vec_r;
    logic [`ACE_NUM_PORTS-1:0] vec_nxt;
    logic [`ACE_DATA_W-1:0] rdata_r;
    logic [`ACE_DATA_W-1:0] rdata_nxt;
    ace_verdict_t verdict_r;
    ace_verdict_t verdict_nxt;

    ////////////////////////////////////////////////////////////////////////
    // address decode

    wire hit_ctrl = (reg_addr == `ACE_OFF_CTRL);
    wire hit_vec = (reg_addr == `ACE_OFF_VEC);
    wire wr_ctrl = reg_wr && hit_ctrl && !upstream_port;
    wire wr_vec = reg_wr && hit_vec;

    ////////////////////////////////////////////////////////////////////////
    // writable vector bits

    logic [`ACE_NUM_PORTS-1:0] vec_wr_mask;

    ace_vec_mask u_vec_mask (
        .port_num(port_num),
        .merged_mode(merged_mode),
        .upstream_port(upstream_port),
        .wr_mask(vec_wr_mask)
    );

    // writes keep only the seven enables; reserved bits never store
    assign ctrl_nxt = wr_ctrl ? (reg_wdata & `ACE_CTRL_MASK) : ctrl_r;
    // hardwired bits are also masked on read so a late merged-mode change cannot expose stale ones
    wire [`ACE_NUM_PORTS-1:0] vec_view = vec_r & vec_wr_mask;
    assign vec_nxt = wr_vec ? (reg_wdata & vec_wr_mask) : vec_r;

    ////////////////////////////////////////////////////////////////////////
    // read path, unmapped offsets read zero

    wire [`ACE_DATA_W-1:0] ctrl_view = upstream_port ? `ACE_CTRL_RST : ctrl_r;
    assign rdata_nxt = !reg_rd ? '0 :
                       hit_ctrl ? ctrl_view :
                       hit_vec ? vec_view : '0;

    ////////////////////////////////////////////////////////////////////////
    // enable decode

    wire en_src = ctrl_view[`ACE_BIT_SRC_VAL];
    wire en_xblk = ctrl_view[`ACE_BIT_XLAT_BLK];
    wire en_rqr = ctrl_view[`ACE_BIT_REQ_REDIR];
    wire en_cpr = ctrl_view[`ACE_BIT_CPL_REDIR];
    wire en_ufw = ctrl_view[`ACE_BIT_UP_FWD];
    wire en_egr = ctrl_view[`ACE_BIT_EGR_CTL];
    wire en_dtp = ctrl_view[`ACE_BIT_DIR_XLAT];

    assign src_val_en = en_src;
    assign up_fwd_en = en_ufw;
    assign vec_size = upstream_port ? 8'h00 : `ACE_VEC_SIZE;

    ////////////////////////////////////////////////////////////////////////
    // routing verdict; priority: block, then redirect, then forward

    wire src_fail = en_src && !req_in.src_ok;
    wire xlat_fail = en_xblk && req_in.translated;
    wire egr_hit = en_egr && req_in.p2p && vec_view[req_in.dest];
    // a translated request with direct translated control bypasses redirect
    wire dtp_bypass = en_dtp && req_in.translated && !req_in.is_cpl;
    wire req_redir = en_rqr && req_in.p2p && !req_in.is_cpl;
    wire cpl_redir = en_cpr && req_in.p2p && req_in.is_cpl;
    // egress hit redirects when request redirect is on, otherwise blocks
    wire egr_redir = egr_hit && en_rqr;
    wire egr_block = egr_hit && !en_rqr;

    ace_route_t route;
    assign route = (src_fail || xlat_fail || egr_block) ? ACE_ROUTE_BLOCK :
                   (((req_redir || egr_redir) && !dtp_bypass) || cpl_redir) ? ACE_ROUTE_REDIRECT :
                   ACE_ROUTE_FORWARD;

    assign verdict_nxt.valid = req_in.valid;
    assign verdict_nxt.forward = req_in.valid && (route == ACE_ROUTE_FORWARD);
    assign verdict_nxt.redirect = req_in.valid && (route == ACE_ROUTE_REDIRECT);
    assign verdict_nxt.block = req_in.valid && (route == ACE_ROUTE_BLOCK);

    ////////////////////////////////////////////////////////////////////////
    // state, frozen while clk_en is low

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= `ACE_CTRL_RST;
            vec_r <= `ACE_VEC_RST;
            rdata_r <= '0;
            verdict_r <= '0;
        end else if (clk_en) begin
            ctrl_r <= ctrl_nxt;
            vec_r <= vec_nxt;
            rdata_r <= rdata_nxt;
            verdict_r <= verdict_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign verdict = verdict_r;

endmodule : ace_control_egress

// >>> hdl/ace_consts.svh
// Purpose: offsets, field positions and reset values of the port isolation register bank
// Assumes: 16-bit registers reached at their printed offsets over a plain port
// Notes: definitions only
`ifndef ACE_CONSTS_SVH
`define ACE_CONSTS_SVH

`define ACE_ADDR_W 12
`define ACE_DATA_W 16
`define ACE_OFF_CTRL 12'h326
`define ACE_OFF_VEC 12'h328
`define ACE_CTRL_RST 16'h0000
`define ACE_VEC_RST 16'h0000
`define ACE_CTRL_MASK 16'h007F
`define ACE_BIT_SRC_VAL 0
`define ACE_BIT_XLAT_BLK 1
`define ACE_BIT_REQ_REDIR 2
`define ACE_BIT_CPL_REDIR 3
`define ACE_BIT_UP_FWD 4
`define ACE_BIT_EGR_CTL 5
`define ACE_BIT_DIR_XLAT 6
`define ACE_NUM_PORTS 16
`define ACE_PORT_W 4
`define ACE_VEC_SIZE 8'h10

`endif

// >>> hdl/ace_pkg.sv
// Purpose: types shared by the port isolation register bank
// Assumes: constants come from ace_consts.svh
// Notes: none
`include "ace_consts.svh"

package ace_pkg;

    // one request offered to the egress check
    typedef struct packed {
        logic valid;
        logic p2p;
        logic is_cpl;
        logic translated;
        logic src_ok;
        logic [`ACE_PORT_W-1:0] dest;
    } ace_req_t;

    // routing verdict
    typedef struct packed {
        logic valid;
        logic forward;
        logic redirect;
        logic block;
    } ace_verdict_t;

    typedef enum logic [1:0] {
        ACE_ROUTE_FORWARD,
        ACE_ROUTE_REDIRECT,
        ACE_ROUTE_BLOCK
    } ace_route_t;

endpackage : ace_pkg

// >>> hdl/ace_vec_mask.sv
// Purpose: per-bit writable mask of the egress block vector
// Assumes: port number and merged mode are stable, same clock domain
// Notes: one generate loop, one bit per switch port
`timescale 1ns/1ps
`include "ace_consts.svh"

module ace_vec_mask (
    // port identity
    input wire logic [`ACE_PORT_W-1:0] port_num,
    input wire logic merged_mode,
    input wire logic upstream_port,
    // writable bits of the vector
    output logic [`ACE_NUM_PORTS-1:0] wr_mask
);
    import ace_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // a bit is hardwired zero at its own port, at N plus one of an even port N in merged mode, and everywhere upstream
    genvar g;
    generate
        for (g = 0; g < `ACE_NUM_PORTS; g++) begin : g_bit
            // a genvar cannot be part-selected, so it is sized by a cast to the port number width
            wire own_bit = (port_num == `ACE_PORT_W'(g));
            wire pair_bit = merged_mode && !port_num[0] &&
                            (port_num + 4'h1 == `ACE_PORT_W'(g));
            assign wr_mask[g] = !upstream_port && !own_bit && !pair_bit;
        end
    endgenerate

endmodule : ace_vec_mask

// >>> verification/ace_sva_chk_sva.sv
// Purpose: port-level checks of the isolation register bank
// Assumes: straps change only while resetn is low
// Notes: bound from tb_top
`timescale 1ns/1ps
`include "ace_consts.svh"
module ace_sva_chk (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // straps and register port
    input wire logic upstream_port,
    input wire logic merged_mode,
    input wire logic [3:0] port_num,
    input wire logic [11:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // judging path
    input wire ace_pkg::ace_req_t req_in,
    input wire ace_pkg::ace_verdict_t verdict,
    input wire logic src_val_en,
    input wire logic [7:0] vec_size
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////
    // read data, hardwired bits and the verdict pipe
    a_rdata_idle: assert property (clk_en && !reg_rd |=> reg_rdata == 16'h0000) else $error("rdata not idle");
    a_ctrl_reserved: assert property (clk_en && reg_rd && reg_addr == `ACE_OFF_CTRL |=> reg_rdata[15:7] == 9'h000)
        else $error("reserved bits set");
    a_up_zero: assert property (clk_en && reg_rd && upstream_port |=> reg_rdata == 16'h0000) else $error("upstream not zero");
    a_own_bit: assert property (clk_en && reg_rd && reg_addr == `ACE_OFF_VEC |=> !reg_rdata[port_num])
        else $error("own bit set");
    a_merged_pair: assert property (clk_en && reg_rd && merged_mode && !port_num[0] && reg_addr == `ACE_OFF_VEC
        |=> !reg_rdata[port_num + 4'h1]) else $error("merged bit set");
    a_vec_size: assert property (vec_size == (upstream_port ? 8'h00 : 8'h10)) else $error("bad size");
    a_src_block: assert property (clk_en && src_val_en && req_in.valid && !req_in.src_ok |=> verdict.block)
        else $error("bad source passed");
    a_verdict_pipe: assert property (clk_en |=> verdict.valid == $past(req_in.valid) && (!verdict.valid ||
        $onehot({verdict.forward, verdict.redirect, verdict.block}))) else $error("verdict off");
endmodule : ace_sva_chk

// >>> verification/ace_peer_port.sv
// Purpose: peer switch port offering requests to be judged
// Assumes: called at a rising edge or just after one
// Notes: request lives exactly one cycle, then drops to zero
`timescale 1ns/1ps
module ace_peer_port (
    // clock and verdict seen
    input wire logic clk,
    input wire ace_pkg::ace_verdict_t verdict,
    // request driven
    output ace_pkg::ace_req_t req
);
    import ace_pkg::*;
    initial req = '0;
    // one request, then the verdict of the following cycle
    task send(input ace_req_t r, output ace_verdict_t o);
        @(posedge clk);
        req <= r;
        @(posedge clk);
        req <= '0;
        #1 o = verdict;
    endtask : send
endmodule : ace_peer_port

// >>> verification/tb_top.sv
// Purpose: self-checking bench of the isolation register bank
// Assumes: clock enable held high except for one vector write near the end
// Notes: table rows first, strap cases after
`timescale 1ns/1ps
`include "ace_consts.svh"
module tb_top;
    import ace_pkg::*;
    typedef struct packed {logic [11:0] a; logic [15:0] d; logic [15:0] e;} ace_wrow_t;
    typedef struct packed {logic [15:0] c; ace_req_t q; ace_verdict_t e;} ace_vrow_t;
    logic core_clk = 0, resetn = 0, upstream_port = 0, merged_mode = 0, reg_wr = 0, reg_rd = 0, clk_en = 1;
    logic [3:0] port_num = 4'h2;
    logic [11:0] reg_addr = 12'h000;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    ace_req_t req_in;
    ace_verdict_t verdict, v;
    logic src_val_en, up_fwd_en;
    logic [7:0] vec_size;
    int err_count = 0, comparisons = 0;
    // port 2 downstream: own vector bit 2 hardwired, 0x32A unmapped
    ace_wrow_t wrows[5] = '{'{12'h326, 16'hFFFF, 16'h007F}, '{12'h326, 16'h0055, 16'h0055},
        '{12'h328, 16'hFFFF, 16'hFFFB}, '{12'h328, 16'h0004, 16'h0000}, '{12'h32A, 16'hFFFF, 16'h0000}};
    // vector holds bit 3; verdict 9 block, A redirect, C forward
    ace_vrow_t vrows[10] = '{'{16'h0020, 9'h193, 4'h9}, '{16'h0020, 9'h194, 4'hC}, '{16'h0024, 9'h193, 4'hA},
        '{16'h0000, 9'h193, 4'hC}, '{16'h0001, 9'h184, 4'h9}, '{16'h0002, 9'h1B4, 4'h9},
        '{16'h0008, 9'h1D4, 4'hA}, '{16'h0004, 9'h194, 4'hA}, '{16'h0044, 9'h1B4, 4'hC}, '{16'h0010, 9'h194, 4'hC}};
    initial forever #4 core_clk = ~core_clk;
    ace_control_egress DUT (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .upstream_port(upstream_port),
        .merged_mode(merged_mode), .port_num(port_num), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_in(req_in), .verdict(verdict),
        .src_val_en(src_val_en), .up_fwd_en(up_fwd_en), .vec_size(vec_size));
    ace_peer_port PEER (.clk(core_clk), .verdict(verdict), .req(req_in));
    ////////////////////////////////////////////////////////////////
    // shared bus cycles and comparison
    task check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [11:0] a, input logic [15:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, e);
    endtask : rd
    // straps only move while reset is held, four cycles each time
    task rst(input logic up, input logic mg, input logic [3:0] pn);
        @(posedge core_clk);
        resetn <= 1'b0;
        upstream_port <= up;
        merged_mode <= mg;
        port_num <= pn;
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
    endtask : rst
    task summarize;
        $display("checks %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst(1'b0, 1'b0, 4'h2);
        rd(`ACE_OFF_CTRL, 16'h0000);
        rd(`ACE_OFF_VEC, 16'h0000);
        check({8'h00, vec_size}, 16'h0010);
        foreach (wrows[i]) begin
            wr(wrows[i].a, wrows[i].d);
            rd(wrows[i].a, wrows[i].e);
        end
        wr(`ACE_OFF_VEC, 16'h0008);
        foreach (vrows[i]) begin
            wr(`ACE_OFF_CTRL, vrows[i].c);
            PEER.send(vrows[i].q, v);
            check({12'h000, v}, {12'h000, vrows[i].e});
        end
        check({15'h0000, up_fwd_en}, 16'h0001);
        rst(1'b1, 1'b0, 4'h2);
        wr(`ACE_OFF_CTRL, 16'h007F);
        rd(`ACE_OFF_CTRL, 16'h0000);
        check({8'h00, vec_size}, 16'h0000);
        rst(1'b0, 1'b1, 4'h4);
        wr(`ACE_OFF_VEC, 16'hFFFF);
        rd(`ACE_OFF_VEC, 16'hFFCF);
        // a write taken while the clock enable is low must not land
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr(`ACE_OFF_VEC, 16'h0000);
        clk_en <= 1'b1;
        rd(`ACE_OFF_VEC, 16'hFFCF);
        summarize();
    end
    // cuts a hang short
    initial begin
        #200000;
        err_count++;
        summarize();
    end
endmodule : tb_top
bind ace_control_egress ace_sva_chk u_chk (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
    .upstream_port(upstream_port), .merged_mode(merged_mode), .port_num(port_num), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_in(req_in), .verdict(verdict), .src_val_en(src_val_en),
    .vec_size(vec_size));
